// ===== hdl/machine_status_trap_stack.sv
// machine status, interrupt-enable stack and double-trap logic of one hart
// assumes csr, trap and return requests are single-cycle pulses on clk
`timescale 1ns/1ps
module machine_status_trap_stack
   import machine_status_pkg::*;
#(
   parameter int XLEN = 64,
   parameter logic [63:0] IMPL_VERSION = 64'h0,
   parameter logic [63:0] HART_NUMBER = 64'h0,
   parameter bit HAS_S = 1'b1,
   parameter bit HAS_U = 1'b1,
   parameter bit HAS_NMI = 1'b1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // csr access
   input wire logic csr_re,
   input wire logic csr_we,
   input wire logic [11:0] csr_addr,
   input wire logic [XLEN-1:0] csr_wdata,
   output logic [XLEN-1:0] csr_rdata_q,
   // trap entry
   input wire logic trap_valid,
   input wire logic trap_to_m,
   input wire logic trap_is_nmi,
   input wire logic [63:0] trap_pc,
   input wire logic [63:0] trap_cause,
   // trap return
   input wire logic machine_trap_return,
   input wire logic supervisor_trap_return,
   input wire logic nmi_trap_return,
   input wire logic [1:0] nmi_return_priv,
   input wire logic return_virt,
   // state out
   output logic [1:0] priv_q,
   output logic m_int_en_q,
   output logic s_int_en_q,
   output logic modify_priv_bit_q,
   output logic machine_disable_trap_q,
   output logic vs_disable_trap_q,
   output logic nmi_enable_bit_q,
   output logic nmi_redirect_q,
   output logic [63:0] nmi_pc_q,
   output logic [63:0] nmi_cause_q,
   output logic crit_error_q
);
   // ****************************************
   // stored fields and combinational decode signals
   // ****************************************
   logic machine_global_int_en_q;
   logic supervisor_global_int_en_q;
   logic machine_prev_int_en_q;
   logic supervisor_prev_int_en_q;
   logic [1:0] machine_prev_priv_q;
   logic supervisor_prev_priv_q;
   logic supervisor_disable_trap_q;
   logic [63:0] status;
   logic [63:0] wdata;
   logic [1:0] least_priv;
   logic [1:0] ret_priv;
   logic [1:0] mpp_d;
   logic new_mdt;
   logic unexpected;
   logic take_m;
   logic take_s;
   logic nmi_path;
   logic halt_path;
   logic any_ret;
   logic wr_status;
   logic wr_upper;

   assign wdata = 64'(csr_wdata);
   assign least_priv = HAS_U ? PRIV_U : PRIV_M; // [RQ8]
   assign wr_status = csr_we && csr_addr == ADDR_MACHINE_STATUS;
   assign wr_upper = csr_we && XLEN == 32 && csr_addr == ADDR_MACHINE_STATUS_UPPER;
   assign any_ret = machine_trap_return || supervisor_trap_return || nmi_trap_return;

   // ****************************************
   // status word image
   // ****************************************
   always_comb begin
      status = 64'h0; // [RQ23]
      status[SIE_POS] = supervisor_global_int_en_q; // [RQ20]
      status[MIE_POS] = machine_global_int_en_q; // [RQ3] [RQ20]
      status[SUPERVISOR_PREV_INT_EN_POS] = supervisor_prev_int_en_q;
      status[MACHINE_PREV_INT_EN_POS] = machine_prev_int_en_q; // [RQ3]
      status[SPP_POS] = supervisor_prev_priv_q; // [RQ6]
      status[MPP_LO+1:MPP_LO] = machine_prev_priv_q; // [RQ3] [RQ6]
      status[MODIFY_PRIV_BIT_POS] = modify_priv_bit_q;
      status[SDT_POS] = supervisor_disable_trap_q;
      status[MDT_POS] = machine_disable_trap_q;
   end

   // ****************************************
   // legalizing the machine previous privilege
   // ****************************************
   always_comb begin
      mpp_d = machine_prev_priv_q; // [RQ9]
      case (wdata[MPP_LO+1:MPP_LO])
         PRIV_M: mpp_d = PRIV_M;
         PRIV_S: if (HAS_S) mpp_d = PRIV_S;
         PRIV_U: if (HAS_U) mpp_d = PRIV_U; // [RQ10]
         default: mpp_d = machine_prev_priv_q;
      endcase
   end

   // ****************************************
   // trap classification
   // ****************************************
   assign unexpected = trap_valid && !crit_error_q && !(HAS_NMI && trap_is_nmi) && // [RQ15]
      ((trap_to_m && machine_disable_trap_q) || // [RQ14]
       (HAS_NMI && priv_q == PRIV_M && !nmi_enable_bit_q)); // [RQ15]
   assign nmi_path = unexpected && HAS_NMI && nmi_enable_bit_q; // [RQ16]
   assign halt_path = unexpected && !nmi_path; // [RQ17]
   assign take_m = trap_valid && !crit_error_q && !unexpected && trap_to_m && !trap_is_nmi;
   assign take_s = trap_valid && !crit_error_q && !unexpected && !trap_to_m && !trap_is_nmi;
   assign new_mdt = (XLEN == 64) ? wdata[MDT_POS] : machine_disable_trap_q;
   assign ret_priv = machine_trap_return ? machine_prev_priv_q :
      supervisor_trap_return ? {1'b0, supervisor_prev_priv_q} : nmi_return_priv;

   // ****************************************
   // privilege mode and machine stack
   // ****************************************
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         priv_q <= PRIV_RESET;
         machine_global_int_en_q <= 1'b0;
         machine_prev_int_en_q <= 1'b0;
         machine_prev_priv_q <= PRIV_M;
         modify_priv_bit_q <= 1'b0;
      end else if (!crit_error_q && !halt_path) begin // [RQ17]
         if (trap_valid && (nmi_path || trap_is_nmi)) begin
            priv_q <= PRIV_M; // [RQ16]
         end else if (take_m) begin
            machine_prev_int_en_q <= machine_global_int_en_q; // [RQ7]
            machine_global_int_en_q <= 1'b0; // [RQ7]
            machine_prev_priv_q <= (priv_q == PRIV_S && !HAS_S) ? PRIV_M : priv_q; // [RQ7]
            priv_q <= PRIV_M;
         end else if (take_s) begin
            priv_q <= PRIV_S;
         end else if (any_ret) begin
            priv_q <= ret_priv; // [RQ8]
            if (machine_trap_return) begin
               machine_global_int_en_q <= machine_prev_int_en_q; // [RQ8]
               machine_prev_int_en_q <= 1'b1; // [RQ8]
               machine_prev_priv_q <= least_priv; // [RQ8]
            end
            if (!nmi_trap_return && ret_priv != PRIV_M) modify_priv_bit_q <= 1'b0; // [RQ8]
         end else if (wr_status) begin
            machine_global_int_en_q <= wdata[MIE_POS] && !new_mdt; // [RQ12] [RQ13]
            machine_prev_int_en_q <= wdata[MACHINE_PREV_INT_EN_POS];
            machine_prev_priv_q <= mpp_d; // [RQ9]
            modify_priv_bit_q <= HAS_U && wdata[MODIFY_PRIV_BIT_POS];
         end else if (wr_upper && wdata[UPPER_MDT_POS]) begin
            machine_global_int_en_q <= 1'b0; // [RQ12]
         end
      end
   end

   // ****************************************
   // supervisor stack
   // ****************************************
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         supervisor_global_int_en_q <= 1'b0;
         supervisor_prev_int_en_q <= 1'b0;
         supervisor_prev_priv_q <= 1'b0;
      end else if (HAS_S && !crit_error_q && !halt_path && !(trap_valid && !take_s)) begin
         if (take_s) begin
            supervisor_prev_int_en_q <= supervisor_global_int_en_q; // [RQ7]
            supervisor_global_int_en_q <= 1'b0; // [RQ7]
            supervisor_prev_priv_q <= priv_q[0]; // [RQ7]
         end else if (supervisor_trap_return) begin
            supervisor_global_int_en_q <= supervisor_prev_int_en_q; // [RQ8]
            supervisor_prev_int_en_q <= 1'b1; // [RQ8]
            supervisor_prev_priv_q <= !HAS_U; // [RQ8]
         end else if (!any_ret && wr_status) begin
            supervisor_global_int_en_q <= wdata[SIE_POS];
            supervisor_prev_int_en_q <= wdata[SUPERVISOR_PREV_INT_EN_POS];
            supervisor_prev_priv_q <= HAS_U ? wdata[SPP_POS] : 1'b1; // [RQ9]
         end
      end
   end

   // ****************************************
   // disable-trap bits
   // ****************************************
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         machine_disable_trap_q <= MDT_RESET; // [RQ11]
         supervisor_disable_trap_q <= 1'b0;
         vs_disable_trap_q <= 1'b0;
      end else if (!crit_error_q && !halt_path) begin
         if (take_m) begin
            machine_disable_trap_q <= 1'b1; // [RQ14]
         end else if (any_ret && !trap_valid) begin
            if (nmi_trap_return ? ret_priv != PRIV_M : priv_q == PRIV_M) begin
               machine_disable_trap_q <= 1'b0; // [RQ18] [RQ19]
            end
            if (ret_priv == PRIV_U || (ret_priv == PRIV_S && return_virt)) begin
               supervisor_disable_trap_q <= 1'b0; // [RQ18] [RQ19]
            end
            if (ret_priv == PRIV_U && return_virt) begin
               vs_disable_trap_q <= 1'b0; // [RQ18] [RQ19]
            end
         end else if (!trap_valid && wr_status) begin
            if (XLEN == 64) machine_disable_trap_q <= wdata[MDT_POS];
            supervisor_disable_trap_q <= HAS_S && wdata[SDT_POS];
         end else if (!trap_valid && wr_upper) begin
            machine_disable_trap_q <= wdata[UPPER_MDT_POS]; // [RQ4]
         end
      end
   end

   // ****************************************
   // nmi redirection and critical error
   // ****************************************
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         nmi_enable_bit_q <= NMI_ENABLE_BIT_RESET;
         nmi_redirect_q <= 1'b0;
         nmi_pc_q <= 64'h0;
         nmi_cause_q <= 64'h0;
         crit_error_q <= 1'b0;
      end else begin
         nmi_redirect_q <= 1'b0;
         if (halt_path) begin
            crit_error_q <= 1'b1; // [RQ17] [RQ22]
         end else if (!crit_error_q && trap_valid && (nmi_path || (HAS_NMI && trap_is_nmi))) begin
            nmi_pc_q <= trap_pc; // [RQ16]
            nmi_cause_q <= trap_cause; // [RQ16]
            nmi_enable_bit_q <= 1'b0; // [RQ16]
            nmi_redirect_q <= 1'b1;
         end else if (!crit_error_q && !trap_valid && nmi_trap_return) begin
            nmi_enable_bit_q <= 1'b1;
         end
      end
   end

   // ****************************************
   // interrupt enable view
   // ****************************************
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         m_int_en_q <= 1'b0;
         s_int_en_q <= 1'b0;
      end else begin
         m_int_en_q <= !crit_error_q && (priv_q != PRIV_M || machine_global_int_en_q); // [RQ5]
         s_int_en_q <= !crit_error_q && (priv_q == PRIV_U ||
            (priv_q == PRIV_S && supervisor_global_int_en_q)); // [RQ5]
      end
   end

   // ****************************************
   // csr read port
   // ****************************************
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         csr_rdata_q <= '0;
      end else if (csr_re) begin
         case (csr_addr)
            ADDR_IMPL_VERSION: csr_rdata_q <= IMPL_VERSION[XLEN-1:0]; // [RQ1]
            ADDR_HART_NUMBER: csr_rdata_q <= HART_NUMBER[XLEN-1:0]; // [RQ2]
            ADDR_MACHINE_STATUS: csr_rdata_q <= status[XLEN-1:0]; // [RQ3]
            ADDR_MACHINE_STATUS_UPPER: csr_rdata_q <= (XLEN == 32) ?
               XLEN'({1'b0, status[62:UPPER_LO], 4'h0}) : '0; // [RQ4]
            default: csr_rdata_q <= '0;
         endcase
      end
   end

   // ****************************************
   // checks
   // ****************************************
   a_trap_push_stack: assert property (@(posedge clk) disable iff (!rst_b) // [RQ7]
      take_m |=> !machine_global_int_en_q && priv_q == PRIV_M &&
         machine_prev_int_en_q == $past(machine_global_int_en_q))
      else $error("trap entry did not push the enable stack");
   a_trap_sets_mdt: assert property (@(posedge clk) disable iff (!rst_b) // [RQ14]
      take_m |=> machine_disable_trap_q)
      else $error("machine trap did not set disable-trap");
   a_machine_trap_return_pop: assert property (@(posedge clk) disable iff (!rst_b) // [RQ8]
      machine_trap_return && !trap_valid && !crit_error_q |=>
         machine_global_int_en_q == $past(machine_prev_int_en_q) && machine_prev_int_en_q &&
         priv_q == $past(machine_prev_priv_q) && machine_prev_priv_q == least_priv)
      else $error("machine return did not pop the stack");
   a_modify_priv_bit_clear: assert property (@(posedge clk) disable iff (!rst_b) // [RQ8]
      machine_trap_return && !trap_valid && !crit_error_q && machine_prev_priv_q != PRIV_M
         |=> !modify_priv_bit_q)
      else $error("return below machine kept modify-priv");
   a_mdt_write_mie: assert property (@(posedge clk) disable iff (!rst_b) // [RQ12]
      wr_status && !trap_valid && !any_ret && !crit_error_q && new_mdt |=>
         !machine_global_int_en_q)
      else $error("disable-trap write left machine enable set");
   a_mpp_legal: assert property (@(posedge clk) disable iff (!rst_b) // [RQ9]
      machine_prev_priv_q != 2'h2 && (HAS_S || machine_prev_priv_q != PRIV_S))
      else $error("illegal previous privilege held");
   a_nmi_redirect: assert property (@(posedge clk) disable iff (!rst_b) // [RQ16]
      nmi_path |=> nmi_redirect_q && !nmi_enable_bit_q && priv_q == PRIV_M &&
         nmi_pc_q == $past(trap_pc))
      else $error("unexpected trap not redirected to nmi handler");
   a_crit_freeze: assert property (@(posedge clk) disable iff (!rst_b) // [RQ17]
      halt_path |=> crit_error_q && $stable(priv_q) && $stable(machine_disable_trap_q) &&
         $stable(machine_global_int_en_q) ##1 !m_int_en_q && !s_int_en_q)
      else $error("critical error changed state or kept interrupts");
   a_crit_sticky: assert property (@(posedge clk) disable iff (!rst_b) // [RQ22]
      crit_error_q |=> crit_error_q [*2])
      else $error("critical error dropped before reset");
   a_lower_mode_int: assert property (@(posedge clk) disable iff (!rst_b) // [RQ5]
      priv_q == PRIV_U && !crit_error_q |=> m_int_en_q)
      else $error("machine interrupts masked while in user mode");
endmodule : machine_status_trap_stack

// ===== hdl/machine_status_pkg.sv
// constants for the machine status and trap-state block
// assumes a hart pipeline that presents csr accesses, traps and returns
// Behaviour
// RQ1: implementation-version register always readable, default value zero.
// RQ2: hart-number register is read-only, xlen wide, unique per hart.
// RQ3: status register read/write; global enable 3, prev enable 7, prev priv 12:11.
// RQ4: rv32 upper status holds bits 62:36 in 30:4, disable-trap at bit 10.
// RQ5: own-mode interrupts follow global enable; lower off, higher always on.
// RQ6: machine previous privilege two bits, supervisor previous privilege one bit.
// RQ7: trap entry pushes enable into previous enable, clears it, records old mode.
// RQ8: trap return pops enable, switches mode, resets stack, clears modify-priv bit.
// RQ9: previous-privilege fields accept only legal modes; absent mode reads zero.
// RQ10: with only user and machine modes, previous priv reads 00 or 11.
// RQ11: reset sets machine disable-trap bit.
// RQ12: csr write setting disable-trap clears machine global enable.
// RQ13: global enable set by write only when disable-trap is or becomes zero.
// RQ14: machine trap sets disable-trap; trap with it already set is unexpected.
// RQ15: nmi trap never unexpected; machine-mode trap with nmi enable clear is unexpected.
// RQ16: unexpected trap with nmi enabled redirects to nmi handler, records pc, cause.
// RQ17: otherwise hart halts with no state change and raises critical error.
// RQ18: machine/supervisor return in machine mode clears disable-trap bits.
// RQ19: nmi return clears disable-trap only when leaving machine mode.
// RQ20: global enables sit in low status bits for atomic set and clear.
// RQ21: handler software saves state before enabling interrupts or faulting.
// RQ22: critical error is a registered level held until reset.
// RQ23: reserved status fields read zero and ignore writes.
package machine_status_pkg;
   // ****************************************
   // privilege modes
   // ****************************************
   localparam logic [1:0] PRIV_U = 2'h0;
   localparam logic [1:0] PRIV_S = 2'h1;
   localparam logic [1:0] PRIV_M = 2'h3;
   // ****************************************
   // register addresses
   // ****************************************
   localparam logic [11:0] ADDR_IMPL_VERSION = 12'h001;
   localparam logic [11:0] ADDR_HART_NUMBER = 12'h002;
   localparam logic [11:0] ADDR_MACHINE_STATUS = 12'h003;
   localparam logic [11:0] ADDR_MACHINE_STATUS_UPPER = 12'h004;
   // ****************************************
   // status field positions
   // ****************************************
   localparam int SIE_POS = 1;
   localparam int MIE_POS = 3;
   localparam int SUPERVISOR_PREV_INT_EN_POS = 5;
   localparam int MACHINE_PREV_INT_EN_POS = 7;
   localparam int SPP_POS = 8;
   localparam int MPP_LO = 11;
   localparam int MODIFY_PRIV_BIT_POS = 17;
   localparam int SDT_POS = 24;
   localparam int MDT_POS = 42;
   localparam int UPPER_MDT_POS = 10;
   localparam int UPPER_LO = 36;
   // ****************************************
   // reset values
   // ****************************************
   localparam logic MDT_RESET = 1'b1;
   localparam logic NMI_ENABLE_BIT_RESET = 1'b1;
   localparam logic [1:0] PRIV_RESET = PRIV_M;
endpackage : machine_status_pkg

// ===== bench/hart_pipe_model.sv
// pipeline-side model: issues csr accesses, traps and returns
// assumes the block samples requests on the rising edge of clk
`timescale 1ns/1ps
module hart_pipe_model (
   // clock
   input wire logic clk,
   // requests to the block
   output logic csr_re,
   output logic csr_we,
   output logic [11:0] csr_addr,
   output logic [63:0] csr_wdata,
   output logic trap_valid,
   output logic trap_to_m,
   output logic trap_is_nmi,
   output logic [63:0] trap_pc,
   output logic [63:0] trap_cause,
   output logic machine_trap_return,
   output logic supervisor_trap_return,
   output logic nmi_trap_return,
   output logic [1:0] nmi_return_priv,
   output logic return_virt
);
   initial begin
      {csr_re, csr_we, trap_valid, trap_to_m, trap_is_nmi} = 5'h00;
      {machine_trap_return, supervisor_trap_return, nmi_trap_return} = 3'h0;
      return_virt = 1'b0;
      nmi_return_priv = 2'h0;
      csr_addr = 12'h000;
      csr_wdata = 64'h0;
      trap_pc = 64'h0;
      trap_cause = 64'h0;
   end
   // released lines show the inverse of the last value, except trap_to_m and trap_is_nmi, which hold
   task automatic rd(input logic [11:0] a);
      @(negedge clk);
      csr_re = 1'b1;
      csr_addr = a;
      @(negedge clk);
      csr_re = 1'b0;
      csr_addr = ~a;
   endtask : rd
   task automatic wr(input logic [11:0] a, input logic [63:0] d);
      @(negedge clk);
      csr_we = 1'b1;
      csr_addr = a;
      csr_wdata = d;
      @(negedge clk);
      csr_we = 1'b0;
      csr_addr = ~a;
      csr_wdata = ~d;
   endtask : wr
   // one-cycle trap request: back-to-back calls model a nested entry before state is saved
   task automatic trap(input logic m, input logic n, input logic [63:0] p, input logic [63:0] c);
      @(negedge clk);
      trap_valid = 1'b1;
      trap_to_m = m;
      trap_is_nmi = n;
      trap_pc = p;
      trap_cause = c;
      @(negedge clk);
      trap_valid = 1'b0;
      trap_pc = ~p;
      trap_cause = ~c;
   endtask : trap
   // k: 0 machine, 1 supervisor, 2 nmi return
   task automatic ret(input int k, input logic [1:0] p);
      @(negedge clk);
      machine_trap_return = (k == 0);
      supervisor_trap_return = (k == 1);
      nmi_trap_return = (k == 2);
      nmi_return_priv = p;
      @(negedge clk);
      {machine_trap_return, supervisor_trap_return, nmi_trap_return} = 3'h0;
      nmi_return_priv = ~p;
   endtask : ret
endmodule : hart_pipe_model

// ===== bench/machine_status_trap_stack_tb.sv
// self-checking bench for the machine status and trap-state block
// assumes the pipeline model is compiled before this file
`timescale 1ns/1ps
module machine_status_trap_stack_tb;
   import machine_status_pkg::*;
   localparam logic [63:0] B_DT = 64'h1 << MDT_POS;
   localparam logic [63:0] B_GIE = 64'h1 << MIE_POS;
   localparam logic [63:0] B_SIE = 64'h1 << SIE_POS;
   localparam logic [63:0] B_PIE = 64'h1 << MACHINE_PREV_INT_EN_POS;
   localparam logic [63:0] B_PP3 = 64'h3 << MPP_LO;
   localparam logic [63:0] B_MOD = 64'h1 << MODIFY_PRIV_BIT_POS;
   localparam logic [63:0] B_SUPERVISOR_PREV_INT_EN = 64'h1 << SUPERVISOR_PREV_INT_EN_POS;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic csr_re, csr_we, trap_valid, trap_to_m, trap_is_nmi, return_virt;
   logic machine_trap_return, supervisor_trap_return, nmi_trap_return;
   logic [11:0] csr_addr;
   logic [1:0] nmi_return_priv, priv_q;
   logic [63:0] csr_wdata, trap_pc, trap_cause, csr_rdata_q, nmi_pc_q, nmi_cause_q;
   logic m_int_en_q, s_int_en_q, modify_priv_bit_q, machine_disable_trap_q;
   logic vs_disable_trap_q, nmi_enable_bit_q, nmi_redirect_q, crit_error_q;
   logic [11:0] zaddr [4] = '{ADDR_IMPL_VERSION, ADDR_HART_NUMBER,
      ADDR_MACHINE_STATUS_UPPER, 12'h005};
   int bad_count = 0;
   int comparisons = 0;
   always #2.5 clk = ~clk;
   hart_pipe_model pipe (.clk, .csr_re, .csr_we, .csr_addr, .csr_wdata, .trap_valid,
      .trap_to_m, .trap_is_nmi, .trap_pc, .trap_cause, .machine_trap_return,
      .supervisor_trap_return, .nmi_trap_return, .nmi_return_priv, .return_virt);
   machine_status_trap_stack uut (.clk, .rst_b, .csr_re, .csr_we, .csr_addr, .csr_wdata,
      .csr_rdata_q, .trap_valid, .trap_to_m, .trap_is_nmi, .trap_pc, .trap_cause,
      .machine_trap_return, .supervisor_trap_return, .nmi_trap_return, .nmi_return_priv,
      .return_virt, .priv_q, .m_int_en_q, .s_int_en_q, .modify_priv_bit_q,
      .machine_disable_trap_q, .vs_disable_trap_q, .nmi_enable_bit_q, .nmi_redirect_q,
      .nmi_pc_q, .nmi_cause_q, .crit_error_q);
   // ****
   // compare and control tasks
   // ****
   task automatic chk_w(input logic [63:0] g, input logic [63:0] e, input string s);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %0t %s got %h exp %h", $time, s, g, e);
      end
   endtask : chk_w
   task automatic chk_b(input logic g, input logic e, input string s);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %0t %s got %b exp %b", $time, s, g, e);
      end
   endtask : chk_b
   task automatic rs(input logic [63:0] e, input string s);
      pipe.rd(ADDR_MACHINE_STATUS);
      chk_w(csr_rdata_q, e, s);
   endtask : rs
   task automatic do_reset();
      @(negedge clk);
      rst_b = 1'b0;
      repeat (6) @(negedge clk);
      rst_b = 1'b1;
   endtask : do_reset
   task automatic conclude();
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : conclude
   initial begin
      #20000;
      bad_count++;
      conclude();
   end
   // ****
   // test sequence
   // ****
   initial begin
      do_reset();
      chk_w({62'h0, priv_q}, {62'h0, PRIV_M}, "priv");
      chk_b(machine_disable_trap_q, 1'b1, "dt");
      chk_b(crit_error_q, 1'b0, "crit");
      rs(B_DT | B_PP3, "reset status");
      pipe.wr(ADDR_HART_NUMBER, '1);
      foreach (zaddr[k]) begin
         pipe.rd(zaddr[k]);
         chk_w(csr_rdata_q, 64'h0, "zero reg");
      end
      pipe.wr(ADDR_MACHINE_STATUS, B_DT | B_GIE | B_PP3);
      rs(B_DT | B_PP3, "set dt");
      pipe.wr(ADDR_MACHINE_STATUS, B_GIE | B_PP3 | 64'h8000_0000_0000_0004);
      rs(B_GIE | B_PP3, "clear dt");
      pipe.wr(ADDR_MACHINE_STATUS, B_GIE | B_SIE | (64'h2 << MPP_LO));
      rs(B_GIE | B_SIE | B_PP3, "bad pp");
      chk_b(m_int_en_q, 1'b1, "m en in m");
      chk_b(s_int_en_q, 1'b0, "s en in m");
      pipe.ret(0, PRIV_U);
      rs(B_SIE | B_PIE, "ret to m");
      pipe.wr(ADDR_MACHINE_STATUS, B_PIE | B_MOD);
      chk_b(modify_priv_bit_q, 1'b1, "mod set");
      pipe.ret(0, PRIV_U);
      chk_w({62'h0, priv_q}, {62'h0, PRIV_U}, "priv u");
      chk_b(modify_priv_bit_q, 1'b0, "mod clr");
      rs(B_GIE | B_PIE, "ret to u");
      chk_b(m_int_en_q, 1'b1, "m en in u");
      chk_b(s_int_en_q, 1'b1, "s en in u");
      pipe.trap(1'b1, 1'b0, 64'h100, 64'h8);
      chk_w({62'h0, priv_q}, {62'h0, PRIV_M}, "trap priv");
      rs(B_DT | B_PIE, "trap status");
      pipe.ret(0, PRIV_U);
      chk_b(machine_disable_trap_q, 1'b0, "ret dt");
      rs(B_GIE | B_PIE, "ret status");
      pipe.trap(1'b1, 1'b0, 64'h100, 64'h8);
      pipe.trap(1'b1, 1'b0, 64'h1234, 64'h2);
      for (int k = 0; k < 4 && nmi_redirect_q !== 1'b1; k++) @(negedge clk);
      chk_b(nmi_redirect_q, 1'b1, "redirect");
      chk_w(nmi_pc_q, 64'h1234, "nmi pc");
      chk_w(nmi_cause_q, 64'h2, "nmi cause");
      chk_b(nmi_enable_bit_q, 1'b0, "nmi_enable_bit clr");
      chk_b(crit_error_q, 1'b0, "no crit");
      pipe.ret(2, PRIV_U);
      chk_b(machine_disable_trap_q, 1'b0, "nret dt");
      chk_w({62'h0, priv_q}, {62'h0, PRIV_U}, "nret priv");
      pipe.trap(1'b1, 1'b0, 64'h100, 64'h8);
      pipe.trap(1'b1, 1'b0, 64'h2468, 64'h2);
      pipe.trap(1'b1, 1'b0, 64'h5555, 64'h3);
      for (int k = 0; k < 4 && crit_error_q !== 1'b1; k++) @(negedge clk);
      chk_b(crit_error_q, 1'b1, "crit");
      chk_b(m_int_en_q, 1'b0, "crit m en");
      chk_b(s_int_en_q, 1'b0, "crit s en");
      chk_w(nmi_pc_q, 64'h2468, "crit pc");
      pipe.wr(ADDR_MACHINE_STATUS, 64'h0);
      rs(B_DT, "crit status");
      repeat (20) @(negedge clk);
      chk_b(crit_error_q, 1'b1, "crit held");
      do_reset();
      chk_b(crit_error_q, 1'b0, "crit reset");
      pipe.trap(1'b1, 1'b1, 64'h77, 64'h9);
      repeat (3) @(negedge clk);
      chk_b(crit_error_q, 1'b0, "nmi trap");
      chk_b(machine_disable_trap_q, 1'b1, "nmi dt");
      chk_w(nmi_pc_q, 64'h77, "nmi trap pc");
      pipe.wr(ADDR_MACHINE_STATUS, B_SIE);
      pipe.ret(0, PRIV_U);
      pipe.trap(1'b0, 1'b0, 64'h40, 64'h5);
      chk_w({62'h0, priv_q}, {62'h0, PRIV_S}, "s trap priv");
      rs(B_PIE | B_SUPERVISOR_PREV_INT_EN, "s trap");
      chk_b(m_int_en_q, 1'b1, "m en in s");
      chk_b(s_int_en_q, 1'b0, "s en in s");
      pipe.ret(1, PRIV_U);
      chk_w({62'h0, priv_q}, {62'h0, PRIV_U}, "s ret priv");
      rs(B_SIE | B_PIE | B_SUPERVISOR_PREV_INT_EN, "s ret");
      chk_b(vs_disable_trap_q, 1'b0, "vs dt");
      conclude();
   end
endmodule : machine_status_trap_stack_tb
